// file: bench/sgmd_props.sv
// Checker of the signal modulator top ports
`timescale 1ns/1ps
`default_nettype none
module sgmd_props (
	input wire logic                i_clk,
	input wire logic                i_reset,
	input wire logic                i_hsel,
	input wire logic [31:0]         i_haddr,
	input wire logic [1:0]          i_htrans,
	input wire logic                i_hwrite,
	input wire logic [2:0]          i_hsize,
	input wire logic [31:0]         i_hwdata,
	input wire logic                i_hready,
	input wire logic                o_hreadyout,
	input wire logic                o_hresp,
	input wire logic [31:0]         o_hrdata,
	input wire logic                i_idle,
	input wire sgmd_pkg::sgmd_src_t i_src,
	input wire sgmd_pkg::sgmd_src_t o_pin_block,
	input wire logic                o_modulated_out,
	input wire logic                o_modulated_oe_n,
	input wire logic                o_output_slew_limit
);
	import sgmd_pkg::*;
	logic        wr_ph, uh, hp, lp, uhn, hc, lc, md, run;
	logic [7:0]  ofs;
	logic [15:0] ctrl, src, car, rdv;
	function automatic logic pick_car(logic [3:0] c, sgmd_src_t s);
		if (c == SGMD_CAR_GROUND || c > SGMD_CAR_PWM_LAST) return 1'b0;
		return s[int'(c) + (c > SGMD_CAR_REFERENCE_CLOCK_OUT ? 6 : 0)];
	endfunction
	function automatic logic pick_mod(logic [3:0] c, sgmd_src_t s, logic b);
		if (c == SGMD_MS_MANUAL) return b;
		if (c == 4'hf) return 1'b0;
		return s[c == SGMD_MS_PIN ? 0 : int'(c) + 2];
	endfunction
	function automatic sgmd_src_t blk(logic [15:0] sr, logic [15:0] cr);
		sgmd_src_t b;
		b = '0;
		if (sr[7] && sr[3:0] > 4'h1 && sr[3:0] != 4'hf) b[int'(sr[3:0]) + 2] = 1'b1;
		for (int k = 0; k < 2; k++)
			if (cr[8*k+7] && pick_car(cr[8*k+:4], '1)) b[int'(cr[8*k+:4]) + (cr[8*k+:4] > 4'h3 ? 6 : 0)] = 1'b1;
		return b;
	endfunction
	assign hc = pick_car(car[11:8], i_src) ^ car[14];
	assign lc = pick_car(car[3:0], i_src) ^ car[6];
	assign md = pick_mod(src[3:0], i_src, ctrl[0]);
	assign run = ctrl[15] && !(ctrl[13] && i_idle);
	assign rdv = ofs == SGMD_OFS_CTRL ? ctrl : ofs == SGMD_OFS_SRC ? src : ofs == SGMD_OFS_CAR ? car : 16'h0;
	// Carrier in use, switching on a falling edge of the carrier in use when its sync bit is set, else at once
	always_comb begin
		uhn = uh;
		if (md && !uh && (!car[5] || (lp && !lc))) uhn = 1'b1;
		if (!md && uh && (!car[13] || (hp && !hc))) uhn = 1'b0;
	end
	always_ff @(posedge i_clk) begin
		wr_ph <= !i_reset && i_hsel && i_htrans[1] && i_hready && i_hwrite;
		ofs <= i_haddr[7:0];
		if (i_reset) begin
			ctrl <= 16'h0;
			car <= 16'h0;
			src[15:4] <= 12'h0;
			uh <= 1'b0;
			hp <= 1'b0;
			lp <= 1'b0;
		end else begin
			// Switch state cleared while disabled, held while stopped in idle
			if (!ctrl[15]) begin
				uh <= 1'b0;
				hp <= 1'b0;
				lp <= 1'b0;
			end else if (run) begin
				uh <= uhn;
				hp <= hc;
				lp <= lc;
			end
			if (wr_ph && ofs == SGMD_OFS_CTRL) ctrl <= i_hwdata[15:0] & 16'ha071;
			if (wr_ph && ofs == SGMD_OFS_SRC) src <= i_hwdata[15:0] & 16'h008f;
			if (wr_ph && ofs == SGMD_OFS_CAR) car <= i_hwdata[15:0] & 16'hefef;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_read;
		i_hsel && i_htrans[1] && i_hready && !i_hwrite;
	endsequence
	sequence s_stopped;
		ctrl[15] && ctrl[13] && i_idle;
	endsequence
	a_mix_out: assert property (!$past(i_reset) && $past(run) |->
		o_modulated_out == $past(ctrl[4] ^ (uhn ? hc : lc))) else $error("modulated output differs");
	a_off_level: assert property (!$past(i_reset) && !$past(ctrl[15]) |->
		o_modulated_out == $past(ctrl[4])) else $error("disabled output level wrong");
	a_idle_hold: assert property (s_stopped |=> $stable(o_modulated_out))
		else $error("output moved while stopped in idle");
	a_manual_src: assert property (!$past(i_reset) && $past(run && src[3:0] == 4'h0 && !car[13] && !car[5]) |->
		o_modulated_out == $past(ctrl[4] ^ (ctrl[0] ? hc : lc))) else $error("manual bit path wrong");
	a_unused_src: assert property (!$past(i_reset) && $past(run && src[3:0] == 4'hf && !car[13]) |->
		o_modulated_out == $past(ctrl[4] ^ lc)) else $error("unused source not low");
	a_ground_car: assert property (!$past(i_reset) &&
		$past(run && md && car[11:8] == 4'h0 && !car[13] && !car[5]) |->
		o_modulated_out == $past(ctrl[4] ^ car[14])) else $error("ground carrier wrong");
	a_pin_block: assert property (o_pin_block == blk(src, car))
		else $error("pin block vector wrong");
	a_pin_drive: assert property (o_modulated_oe_n == !ctrl[6] && o_output_slew_limit == ctrl[5] &&
		o_hreadyout && !o_hresp) else $error("pin enable or bus response wrong");
	a_read_data: assert property (s_read |=> o_hrdata == {16'h0, rdv})
		else $error("read data differs from register");
endmodule
`default_nettype wire

// file: bench/sgmd_src_model.sv
// Behavioural model of the peripheral outputs feeding the modulator
`timescale 1ns/1ps
`default_nettype none
module sgmd_src_model (
	input  wire logic            i_clk,
	output sgmd_pkg::sgmd_src_t o_src
);
	import sgmd_pkg::*;
	logic [7:0] cnt = 8'h00;
	always_ff @(posedge i_clk) begin
		cnt <= cnt + 8'h01;
	end
	// Each source runs at its own rate, changing just after the edge
	always_comb begin
		for (int k = 0; k < 17; k++) o_src[k] = (int'(cnt) % (k + 3)) < (k + 3) / 2;
	end
endmodule
`default_nettype wire

// file: bench/tb_sgmd_top.sv
// Testbench of the signal modulator
`timescale 1ns/1ps
`default_nettype none
module tb_sgmd_top;
	import sgmd_pkg::*;
	logic        i_clk = 1'b0, i_reset = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, i_idle = 1'b0;
	logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rdat;
	logic [1:0]  i_htrans = 2'h0;
	logic [2:0]  i_hsize = 3'h2;
	logic        o_hreadyout, o_hresp, o_modulated_out, o_modulated_oe_n, o_output_slew_limit;
	sgmd_src_t   i_src, o_pin_block;
	int          mismatches = 0, comparisons = 0;
	always #2.5 i_clk = ~i_clk;
	sgmd_src_model i_model (.i_clk(i_clk), .o_src(i_src));
	sgmd_top i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
		.i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
		.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_idle(i_idle), .i_src(i_src),
		.o_pin_block(o_pin_block), .o_modulated_out(o_modulated_out), .o_modulated_oe_n(o_modulated_oe_n),
		.o_output_slew_limit(o_output_slew_limit));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [15:0] wd);
		logic rdy;
		@(posedge i_clk);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= {24'h0, a};
		i_hwrite <= wr;
		do begin
			@(negedge i_clk);
			rdy = o_hreadyout;
			@(posedge i_clk);
		end while (!rdy);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= {16'h0, wd};
		do begin
			@(negedge i_clk);
			rdy = o_hreadyout;
			rdat = o_hrdata;
			@(posedge i_clk);
		end while (!rdy);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		ahb(1'b1, a, d);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
		ahb(1'b0, a, 16'h0);
		check(nm, rdat, {16'h0, e});
	endtask
	task automatic out_is(input logic e);
		repeat (2) @(posedge i_clk);
		#1 check("out", {31'h0, o_modulated_out}, {31'h0, e});
	endtask
	task automatic final_report;
		if (mismatches == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		rd("ctrl_rst", SGMD_OFS_CTRL, 16'h0);
		rd("car_rst", SGMD_OFS_CAR, 16'h0);
		check("oe_n_rst", {31'h0, o_modulated_oe_n}, 32'h1);
		check("slew_rst", {31'h0, o_output_slew_limit}, 32'h0);
		check("block_rst", 32'(o_pin_block), 32'h0);
		wr(SGMD_OFS_SRC, 16'hffff);
		rd("src_rw", SGMD_OFS_SRC, 16'h008f);
		wr(SGMD_OFS_CTRL, 16'hffff);
		rd("ctrl_rw", SGMD_OFS_CTRL, 16'ha071);
		check("slew_on", {31'h0, o_output_slew_limit}, 32'h1);
		wr(SGMD_OFS_CAR, 16'hffff);
		rd("car_rw", SGMD_OFS_CAR, 16'hefef);
		wr(8'h0c, 16'hffff);
		rd("gap", 8'h0c, 16'h0);
		wr(SGMD_OFS_SRC, 16'h0085);
		@(posedge i_clk) i_reset <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		rd("src_kept", SGMD_OFS_SRC, 16'h0005);
		rd("ctrl_clr", SGMD_OFS_CTRL, 16'h0);
		// High carrier forced to 1, low carrier ground
		wr(SGMD_OFS_SRC, 16'h0000);
		wr(SGMD_OFS_CAR, 16'h4000);
		for (int i = 0; i < 4; i++) begin
			wr(SGMD_OFS_CTRL, 16'h8040 | 16'(i & 1) | 16'(i & 2) << 3);
			out_is(i[0] ^ i[1]);
		end
		check("oe_n_on", {31'h0, o_modulated_oe_n}, 32'h0);
		wr(SGMD_OFS_CTRL, 16'h0051);
		out_is(1'b1);
		wr(SGMD_OFS_CAR, 16'h4040);
		wr(SGMD_OFS_CTRL, 16'h8040);
		out_is(1'b1);
		wr(SGMD_OFS_CAR, 16'h4000);
		wr(SGMD_OFS_CTRL, 16'ha041);
		out_is(1'b1);
		@(posedge i_clk) i_idle <= 1'b1;
		wr(SGMD_OFS_CTRL, 16'ha040);
		out_is(1'b1);
		wr(SGMD_OFS_CTRL, 16'h8040);
		out_is(1'b0);
		@(posedge i_clk) i_idle <= 1'b0;
		// The modulation input pin source owns no output pin, so nothing to block for it
		for (int c = 1; c < 16; c++) begin
			wr(SGMD_OFS_SRC, 16'h0080 | 16'(c));
			repeat (8) @(posedge i_clk);
			check("src_block", 32'(o_pin_block), (c == 1 || c == 15) ? 0 : 32'h1 << (c + 2));
		end
		wr(SGMD_OFS_SRC, 16'h0002);
		@(negedge i_clk);
		check("src_free", 32'(o_pin_block), 32'h0);
		wr(SGMD_OFS_SRC, 16'h0000);
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 16; c++) begin
				wr(SGMD_OFS_CTRL, 16'h8040 | 16'(s));
				wr(SGMD_OFS_CAR, s ? (16'h8000 | 16'(c) << 8) : (16'h0080 | 16'(c)));
				repeat (8) @(posedge i_clk);
				check("car_block", 32'(o_pin_block), (c == 0 || c > 10) ? 0 : 32'h1 << (c < 4 ? c : c + 6));
			end
		end
		for (int k = 0; k < 2; k++) begin
			// Synchronised switching on a running carrier
			wr(SGMD_OFS_CAR, k ? 16'h0021 : 16'h2100);
			for (int b = 0; b < 4; b++) begin
				wr(SGMD_OFS_CTRL, 16'h8040 | 16'(b & 1));
				repeat (12) @(posedge i_clk);
			end
		end
		final_report;
	end
endmodule
bind sgmd_top sgmd_props i_props (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_idle(i_idle), .i_src(i_src),
	.o_pin_block(o_pin_block), .o_modulated_out(o_modulated_out), .o_modulated_oe_n(o_modulated_oe_n),
	.o_output_slew_limit(o_output_slew_limit));
`default_nettype wire

// file: hw/sgmd_ahb_slave.sv
// AHB-Lite slave front end for three 16-bit registers
`timescale 1ns/1ps
`default_nettype none
module sgmd_ahb_slave (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	input  wire logic [15:0] i_rd_ctrl,
	input  wire logic [15:0] i_rd_src,
	input  wire logic [15:0] i_rd_car,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic [31:0]      o_hrdata,
	output logic             o_wr_en,
	output logic [7:0]       o_wr_ofs,
	output logic [15:0]      o_wr_data
);
	import sgmd_pkg::*;

	logic       wr_r, wr_nxt;
	logic       rd_r, rd_nxt;
	logic [7:0] ofs_r, ofs_nxt;
	logic       take;

	always_comb begin
		take = i_hsel && i_htrans[1] && i_hready;
		wr_nxt = take && i_hwrite;
		rd_nxt = take && !i_hwrite;
		ofs_nxt = take ? i_haddr[7:0] : ofs_r;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			ofs_r <= 8'h00;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			ofs_r <= ofs_nxt;
		end
	end

	// Zero wait states, always OKAY; unmapped reads give zero
	always_comb begin
		o_hreadyout = 1'b1;
		o_hresp = 1'b0;
		o_wr_en = wr_r;
		o_wr_ofs = ofs_r;
		o_wr_data = i_hwdata[15:0];
		o_hrdata = 32'h0000_0000;
		if (rd_r) begin
			unique case (ofs_r)
				SGMD_OFS_CTRL: o_hrdata = {16'h0000, i_rd_ctrl};
				SGMD_OFS_SRC:  o_hrdata = {16'h0000, i_rd_src};
				SGMD_OFS_CAR:  o_hrdata = {16'h0000, i_rd_car};
				default:       o_hrdata = 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: hw/sgmd_carrier_sel.sv
// Carrier source selection, polarity and pin block for one carrier
`timescale 1ns/1ps
`default_nettype none
module sgmd_carrier_sel (
	input  wire logic                  i_reset,
	input  wire sgmd_pkg::sgmd_car_cfg_t i_cfg,
	input  wire sgmd_pkg::sgmd_src_t    i_src,
	output logic                       o_carrier,
	output sgmd_pkg::sgmd_src_t         o_block
);
	import sgmd_pkg::*;

	logic      raw;
	logic [2:0] pwm_idx;
	sgmd_src_t hit;

	always_comb begin
		raw = 1'b0;
		hit = '0;
		pwm_idx = 3'(i_cfg.sel - SGMD_CAR_PWM_BASE);
		if (i_cfg.sel == SGMD_CAR_CIN1) begin
			raw = i_src.cin1;
			hit.cin1 = 1'b1;
		end else if (i_cfg.sel == SGMD_CAR_CIN2) begin
			raw = i_src.cin2;
			hit.cin2 = 1'b1;
		end else if (i_cfg.sel == SGMD_CAR_REFERENCE_CLOCK_OUT) begin
			raw = i_src.reference_clock_out;
			hit.reference_clock_out = 1'b1;
		end else if (i_cfg.sel >= SGMD_CAR_PWM_BASE && i_cfg.sel <= SGMD_CAR_PWM_LAST) begin
			raw = i_src.pwm[pwm_idx];
			hit.pwm[pwm_idx] = 1'b1;
		end
		// Ground and reserved codes leave raw at 0
		// Carrier polarity inversion
		o_carrier = raw ^ i_cfg.pol;
		o_block = (i_cfg.out_dis && !i_reset) ? hit : '0;
	end
endmodule
`default_nettype wire

// file: hw/sgmd_pkg.sv
// Shared constants and types of the signal modulator
package sgmd_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] SGMD_OFS_CTRL = 8'h00;
	localparam logic [7:0] SGMD_OFS_SRC  = 8'h04;
	localparam logic [7:0] SGMD_OFS_CAR  = 8'h08;

	// Field positions of modulator_control
	localparam int unsigned SGMD_CTRL_ENABLE    = 15;
	localparam int unsigned SGMD_CTRL_IDLE_STOP = 13;
	localparam int unsigned SGMD_CTRL_OUT_EN    = 6;
	localparam int unsigned SGMD_CTRL_SLEW      = 5;
	localparam int unsigned SGMD_CTRL_OUT_POL   = 4;
	localparam int unsigned SGMD_CTRL_MAN_BIT   = 0;

	// Field positions of modulation_source_select
	localparam int unsigned SGMD_SRC_DISABLE = 7;
	localparam int unsigned SGMD_SRC_SEL_LSB = 0;

	// Field positions of carrier_select
	localparam int unsigned SGMD_CAR_H_DIS   = 15;
	localparam int unsigned SGMD_CAR_H_POL   = 14;
	localparam int unsigned SGMD_CAR_H_SYNC  = 13;
	localparam int unsigned SGMD_CAR_H_SEL   = 8;
	localparam int unsigned SGMD_CAR_L_DIS   = 7;
	localparam int unsigned SGMD_CAR_L_POL   = 6;
	localparam int unsigned SGMD_CAR_L_SYNC  = 5;
	localparam int unsigned SGMD_CAR_L_SEL   = 0;

	// Values after reset
	localparam logic       SGMD_RST_BIT   = 1'b0;
	localparam logic [3:0] SGMD_RST_CSEL  = 4'h0;

	// Modulation source codes
	localparam logic [3:0] SGMD_MS_MANUAL    = 4'h0;
	localparam logic [3:0] SGMD_MS_PIN       = 4'h1;
	localparam logic [3:0] SGMD_MS_SPI_BASE  = 4'h2;
	localparam logic [3:0] SGMD_MS_UART_BASE = 4'h4;
	localparam logic [3:0] SGMD_MS_PWM_BASE  = 4'h8;
	localparam logic [3:0] SGMD_MS_PWM_LAST  = 4'he;

	// Carrier source codes, shared by high and low carrier
	localparam logic [3:0] SGMD_CAR_GROUND   = 4'h0;
	localparam logic [3:0] SGMD_CAR_CIN1     = 4'h1;
	localparam logic [3:0] SGMD_CAR_CIN2     = 4'h2;
	localparam logic [3:0] SGMD_CAR_REFERENCE_CLOCK_OUT     = 4'h3;
	localparam logic [3:0] SGMD_CAR_PWM_BASE = 4'h4;
	localparam logic [3:0] SGMD_CAR_PWM_LAST = 4'ha;

	// All candidate sources, and also the per-source pin block vector
	typedef struct packed {
		logic [6:0] pwm;
		logic [3:0] uart;
		logic [1:0] spi;
		logic       reference_clock_out;
		logic       cin2;
		logic       cin1;
		logic       modin;
	} sgmd_src_t;

	// Conditioning settings of one carrier
	typedef struct packed {
		logic       out_dis;
		logic       pol;
		logic       sync;
		logic [3:0] sel;
	} sgmd_car_cfg_t;

endpackage

// file: hw/sgmd_top.sv
// Signal modulator top: registers, source selection, carrier switching, output pin
`timescale 1ns/1ps
`default_nettype none
module sgmd_top (
	input  wire logic                i_clk,
	input  wire logic                i_reset,
	// AHB-Lite slave
	input  wire logic                i_hsel,
	input  wire logic [31:0]         i_haddr,
	input  wire logic [1:0]          i_htrans,
	input  wire logic                i_hwrite,
	input  wire logic [2:0]          i_hsize,
	input  wire logic [31:0]         i_hwdata,
	input  wire logic                i_hready,
	output logic                     o_hreadyout,
	output logic                     o_hresp,
	output logic [31:0]              o_hrdata,
	// Chip state and candidate sources
	input  wire logic                i_idle,
	input  wire sgmd_pkg::sgmd_src_t i_src,
	// Pin blocks toward peripheral output pins
	output sgmd_pkg::sgmd_src_t      o_pin_block,
	// Modulated output pin
	output logic                     o_modulated_out,
	output logic                     o_modulated_oe_n,
	output logic                     o_output_slew_limit
);
	import sgmd_pkg::*;

	// Control register fields
	logic          modulator_enable_r, modulator_enable_nxt;
	logic          idle_stop_r, idle_stop_nxt;
	logic          output_pin_enable_r, output_pin_enable_nxt;
	logic          output_slew_limit_r, output_slew_limit_nxt;
	logic          output_polarity_r, output_polarity_nxt;
	logic          manual_modulation_bit_r, manual_modulation_bit_nxt;
	// Source select fields
	logic          source_output_disable_r, source_output_disable_nxt;
	logic [3:0]    modulation_source_sel_r, modulation_source_sel_nxt;
	// Carrier select fields
	sgmd_car_cfg_t high_cfg_r, high_cfg_nxt;
	sgmd_car_cfg_t low_cfg_r, low_cfg_nxt;

	// Bus side
	logic          wr_en;
	logic [7:0]    wr_ofs;
	logic [15:0]   wr_data;
	logic [15:0]   rd_ctrl;
	logic [15:0]   rd_src;
	logic [15:0]   rd_car;

	// Datapath
	logic          high_carrier;
	logic          low_carrier;
	sgmd_src_t     high_block;
	sgmd_src_t     low_block;
	sgmd_src_t     mod_hit;
	logic          mod_sig;
	logic [2:0]    mod_idx;
	logic          running;
	logic          high_fall;
	logic          low_fall;
	logic          gated;

	// Switching state
	logic          use_high_r, use_high_nxt;
	logic          high_prev_r, high_prev_nxt;
	logic          low_prev_r, low_prev_nxt;
	logic          mod_out_r, mod_out_nxt;

	sgmd_ahb_slave u_bus (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_hsel      (i_hsel),
		.i_haddr     (i_haddr),
		.i_htrans    (i_htrans),
		.i_hwrite    (i_hwrite),
		.i_hsize     (i_hsize),
		.i_hwdata    (i_hwdata),
		.i_hready    (i_hready),
		.i_rd_ctrl   (rd_ctrl),
		.i_rd_src    (rd_src),
		.i_rd_car    (rd_car),
		.o_hreadyout (o_hreadyout),
		.o_hresp     (o_hresp),
		.o_hrdata    (o_hrdata),
		.o_wr_en     (wr_en),
		.o_wr_ofs    (wr_ofs),
		.o_wr_data   (wr_data)
	);

	// Register write decode
	always_comb begin
		modulator_enable_nxt = modulator_enable_r;
		idle_stop_nxt = idle_stop_r;
		output_pin_enable_nxt = output_pin_enable_r;
		output_slew_limit_nxt = output_slew_limit_r;
		output_polarity_nxt = output_polarity_r;
		manual_modulation_bit_nxt = manual_modulation_bit_r;
		source_output_disable_nxt = source_output_disable_r;
		modulation_source_sel_nxt = modulation_source_sel_r;
		high_cfg_nxt = high_cfg_r;
		low_cfg_nxt = low_cfg_r;
		if (wr_en && wr_ofs == SGMD_OFS_CTRL) begin
			modulator_enable_nxt = wr_data[SGMD_CTRL_ENABLE];
			idle_stop_nxt = wr_data[SGMD_CTRL_IDLE_STOP];
			output_pin_enable_nxt = wr_data[SGMD_CTRL_OUT_EN];
			output_slew_limit_nxt = wr_data[SGMD_CTRL_SLEW];
			output_polarity_nxt = wr_data[SGMD_CTRL_OUT_POL];
			manual_modulation_bit_nxt = wr_data[SGMD_CTRL_MAN_BIT];
		end
		if (wr_en && wr_ofs == SGMD_OFS_SRC) begin
			source_output_disable_nxt = wr_data[SGMD_SRC_DISABLE];
			modulation_source_sel_nxt = wr_data[SGMD_SRC_SEL_LSB +: 4];
		end
		if (wr_en && wr_ofs == SGMD_OFS_CAR) begin
			high_cfg_nxt.out_dis = wr_data[SGMD_CAR_H_DIS];
			high_cfg_nxt.pol = wr_data[SGMD_CAR_H_POL];
			high_cfg_nxt.sync = wr_data[SGMD_CAR_H_SYNC];
			high_cfg_nxt.sel = wr_data[SGMD_CAR_H_SEL +: 4];
			low_cfg_nxt.out_dis = wr_data[SGMD_CAR_L_DIS];
			low_cfg_nxt.pol = wr_data[SGMD_CAR_L_POL];
			low_cfg_nxt.sync = wr_data[SGMD_CAR_L_SYNC];
			low_cfg_nxt.sel = wr_data[SGMD_CAR_L_SEL +: 4];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			modulator_enable_r <= SGMD_RST_BIT;
			idle_stop_r <= SGMD_RST_BIT;
			output_pin_enable_r <= SGMD_RST_BIT;
			output_slew_limit_r <= SGMD_RST_BIT;
			output_polarity_r <= SGMD_RST_BIT;
			manual_modulation_bit_r <= SGMD_RST_BIT;
			// Source disable cleared by reset, loaded from bit 7 by a write to the source register
			source_output_disable_r <= SGMD_RST_BIT;
			high_cfg_r <= '{out_dis: SGMD_RST_BIT, pol: SGMD_RST_BIT, sync: SGMD_RST_BIT, sel: SGMD_RST_CSEL};
			low_cfg_r <= '{out_dis: SGMD_RST_BIT, pol: SGMD_RST_BIT, sync: SGMD_RST_BIT, sel: SGMD_RST_CSEL};
		end else begin
			modulator_enable_r <= modulator_enable_nxt;
			idle_stop_r <= idle_stop_nxt;
			output_pin_enable_r <= output_pin_enable_nxt;
			output_slew_limit_r <= output_slew_limit_nxt;
			output_polarity_r <= output_polarity_nxt;
			manual_modulation_bit_r <= manual_modulation_bit_nxt;
			source_output_disable_r <= source_output_disable_nxt;
			high_cfg_r <= high_cfg_nxt;
			low_cfg_r <= low_cfg_nxt;
		end
	end

	// Source field keeps its value through reset
	always_ff @(posedge i_clk) begin
		modulation_source_sel_r <= modulation_source_sel_nxt;
	end

	// Read back
	always_comb begin
		rd_ctrl = 16'h0000;
		rd_ctrl[SGMD_CTRL_ENABLE] = modulator_enable_r;
		rd_ctrl[SGMD_CTRL_IDLE_STOP] = idle_stop_r;
		rd_ctrl[SGMD_CTRL_OUT_EN] = output_pin_enable_r;
		rd_ctrl[SGMD_CTRL_SLEW] = output_slew_limit_r;
		rd_ctrl[SGMD_CTRL_OUT_POL] = output_polarity_r;
		rd_ctrl[SGMD_CTRL_MAN_BIT] = manual_modulation_bit_r;
		rd_src = 16'h0000;
		rd_src[SGMD_SRC_DISABLE] = source_output_disable_r;
		rd_src[SGMD_SRC_SEL_LSB +: 4] = modulation_source_sel_r;
		rd_car = 16'h0000;
		rd_car[SGMD_CAR_H_DIS] = high_cfg_r.out_dis;
		rd_car[SGMD_CAR_H_POL] = high_cfg_r.pol;
		rd_car[SGMD_CAR_H_SYNC] = high_cfg_r.sync;
		rd_car[SGMD_CAR_H_SEL +: 4] = high_cfg_r.sel;
		rd_car[SGMD_CAR_L_DIS] = low_cfg_r.out_dis;
		rd_car[SGMD_CAR_L_POL] = low_cfg_r.pol;
		rd_car[SGMD_CAR_L_SYNC] = low_cfg_r.sync;
		rd_car[SGMD_CAR_L_SEL +: 4] = low_cfg_r.sel;
	end

	// Both carriers share one selector design
	sgmd_carrier_sel u_high (
		.i_reset   (i_reset),
		.i_cfg     (high_cfg_r),
		.i_src     (i_src),
		.o_carrier (high_carrier),
		.o_block   (high_block)
	);

	sgmd_carrier_sel u_low (
		.i_reset   (i_reset),
		.i_cfg     (low_cfg_r),
		.i_src     (i_src),
		.o_carrier (low_carrier),
		.o_block   (low_block)
	);

	always_comb begin
		mod_sig = 1'b0;
		mod_hit = '0;
		mod_idx = 3'h0;
		if (modulation_source_sel_r == SGMD_MS_MANUAL) begin
			mod_sig = manual_modulation_bit_r;
		end else if (modulation_source_sel_r == SGMD_MS_PIN) begin
			mod_sig = i_src.modin;
		end else if (modulation_source_sel_r < SGMD_MS_UART_BASE) begin
			mod_idx = 3'(modulation_source_sel_r - SGMD_MS_SPI_BASE);
			mod_sig = i_src.spi[mod_idx[0]];
			mod_hit.spi[mod_idx[0]] = 1'b1;
		end else if (modulation_source_sel_r < SGMD_MS_PWM_BASE) begin
			mod_idx = 3'(modulation_source_sel_r - SGMD_MS_UART_BASE);
			mod_sig = i_src.uart[mod_idx[1:0]];
			mod_hit.uart[mod_idx[1:0]] = 1'b1;
		end else if (modulation_source_sel_r <= SGMD_MS_PWM_LAST) begin
			mod_idx = 3'(modulation_source_sel_r - SGMD_MS_PWM_BASE);
			mod_sig = i_src.pwm[mod_idx];
			mod_hit.pwm[mod_idx] = 1'b1;
		end
	end

	// Pin blocks from all three selections
	always_comb begin
		o_pin_block = high_block | low_block;
		if (source_output_disable_r && !i_reset) begin
			o_pin_block = o_pin_block | mod_hit;
		end
	end

	// Carrier switching and output
	always_comb begin
		// Run only when enabled and not stopped in idle
		running = modulator_enable_r && !(idle_stop_r && i_idle);
		high_fall = high_prev_r && !high_carrier;
		low_fall = low_prev_r && !low_carrier;
		use_high_nxt = use_high_r;
		high_prev_nxt = high_prev_r;
		low_prev_nxt = low_prev_r;
		mod_out_nxt = mod_out_r;
		gated = 1'b0;
		if (!modulator_enable_r) begin
			use_high_nxt = 1'b0;
			high_prev_nxt = 1'b0;
			low_prev_nxt = 1'b0;
			mod_out_nxt = output_polarity_r;
		end else if (running) begin
			high_prev_nxt = high_carrier;
			low_prev_nxt = low_carrier;
			if (mod_sig && !use_high_r) begin
				use_high_nxt = !low_cfg_r.sync || low_fall;
			end else if (!mod_sig && use_high_r) begin
				use_high_nxt = high_cfg_r.sync && !high_fall;
			end
			// Selected carrier: high carrier while use_high_nxt, else low carrier
			gated = (use_high_nxt && high_carrier) || (!use_high_nxt && low_carrier);
			mod_out_nxt = gated ^ output_polarity_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			use_high_r <= 1'b0;
			high_prev_r <= 1'b0;
			low_prev_r <= 1'b0;
			mod_out_r <= 1'b0;
		end else begin
			use_high_r <= use_high_nxt;
			high_prev_r <= high_prev_nxt;
			low_prev_r <= low_prev_nxt;
			mod_out_r <= mod_out_nxt;
		end
	end

	// Pin driven only when output enabled
	always_comb begin
		o_modulated_out = mod_out_r;
		o_modulated_oe_n = !output_pin_enable_r;
		o_output_slew_limit = output_slew_limit_r;
	end
endmodule
`default_nettype wire
